// >>> common/ebc_pkg.sv
// Constants, carrier types and state codes of the external bus cycle
// controller. Assumes a single 10 MHz system clock with synchronous reset.
//
// What this block does
// - On-chip module accesses finish in two system clocks without wait states.
// - Regular external cycles ended by size acknowledge take at least three clocks.
// - Fast-termination cycles finish in two clocks using an internal acknowledge.
// - Fast termination may insert a programmable number of wait states first.
// - Each system clock is one controller state; the clock output stays high after reset.
// - Read data is captured one rising clock edge after the acknowledge is seen.
// - Acknowledge seen at the S2 rising edge gives a three-clock cycle.
// - Drive address, size and direction first, then strobes.
// - Wait cycles are added one clock at a time until exactly one acknowledge line is low.
// - Always-on bus monitor raises bus error after its period, at most 64 clocks.
// - Bus error with halt behaves exactly like bus error alone.
// - Word and long reads take two bytes per cycle from a 16-bit port at an even address with two or more bytes left, else one; byte reads one byte.
// - Word and long writes put two bytes per cycle to a 16-bit port at an even address with two or more bytes left, else one; byte writes one byte.
// - Acknowledge, bus error and halt inputs are de-skewed, data inputs are not, and outputs at cycle edges.
// - Acknowledge code 11 waits, 10 is 8-bit, 01 is 16-bit, 00 reserved.
// - Size outputs give bytes left: 01 one, 10 two, 11 three, 00 four.
package ebc_pkg;

	localparam logic [1:0] ACK_WAIT   = 2'h1 + 2'h2;
	localparam logic [1:0] ACK_PORT8  = 2'h2;
	localparam logic [1:0] ACK_PORT16 = 2'h1;
	localparam logic [1:0] ACK_RSVD   = 2'h0;

	localparam logic [1:0] SIZE_BYTE  = 2'h1;
	localparam logic [1:0] SIZE_WORD  = 2'h2;
	localparam logic [1:0] SIZE_THREE = 2'h3;
	localparam logic [1:0] SIZE_LONG  = 2'h0;

	localparam int         BMON_MAX_CYCLES = 64;
	localparam logic [1:0] BMON_RESET_SEL  = 2'h3;
	localparam logic [3:0] FT_WAIT_RESET   = 4'h0;

	typedef enum logic [2:0] {
		EBC_IDLE  = 3'h0,
		EBC_INT   = 3'h1,
		EBC_ADDR  = 3'h2,
		EBC_STRB  = 3'h3,
		EBC_WAIT  = 3'h4,
		EBC_LATCH = 3'h5,
		EBC_END   = 3'h6
	} ebc_state_t;

	typedef struct packed {
		logic        internal;
		logic        fast;
		logic        write;
		logic [1:0]  size;
		logic [23:0] addr;
		logic [31:0] wdata;
	} ebc_req_t;

	typedef struct packed {
		logic        done;
		logic        bus_error;
		logic        halted;
		logic [31:0] rdata;
	} ebc_rsp_t;

	typedef struct packed {
		logic        addr_strobe_n;
		logic        data_strobe_n;
		logic        read_not_write;
		logic [1:0]  xfer_size;
		logic [23:0] addr;
	} ebc_bus_t;

endpackage

// >>> src/ebc_bus_monitor.sv
// Bus monitor that times out a cycle with no termination.
// Assumes the caller drives active and clear from the cycle controller.
`timescale 1ns/1ps
module ebc_bus_monitor
	import ebc_pkg::*;
#(
	parameter int MAX_CYCLES = BMON_MAX_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       active,
	input  wire logic       clear,
	input  wire logic [1:0] bus_monitor_period,
	output logic            timeout
);
	logic [6:0] count;
	logic [6:0] limit;

	// Period select gives 8, 16, 32 or 64 clocks; the monitor cannot be off.
	always_comb begin
		limit = 7'(MAX_CYCLES >> (2'h3 - bus_monitor_period));
	end

	always_ff @(posedge clk) begin
		if (!nrst || clear || !active) begin
			count <= 7'h00;
		end else if (count < limit) begin
			count <= count + 7'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || clear || !active) begin
			timeout <= 1'b0;
		end else begin
			timeout <= (count + 7'h01 >= limit);
		end
	end

	AST_BMON_BOUND: assert property (@(posedge clk) disable iff (!nrst)
		count <= 7'(MAX_CYCLES)) else $error("Monitor count overran.");
endmodule

// >>> src/ebc_cycle_ctrl.sv
// External bus cycle controller: sequences internal, regular and
// fast-termination cycles with dynamic bus sizing.
// Assumes bus inputs synchronous to clk, one request held until done.
// The clock out is held high out of reset, so it has no high and low phases.
`timescale 1ns/1ps
module ebc_cycle_ctrl
	import ebc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       req_valid,
	input  wire ebc_pkg::ebc_req_t req,
	output logic            req_ready,
	output ebc_pkg::ebc_rsp_t rsp,
	input  wire logic [3:0] ft_wait_states,
	input  wire logic [1:0] bus_monitor_period,
	input  wire logic [1:0] size_ack_n,
	input  wire logic       bus_error_n,
	input  wire logic       halt_n,
	input  wire logic [15:0] data_in,
	output logic [15:0]     data_out,
	output logic            data_oe_n,
	output ebc_pkg::ebc_bus_t bus,
	output logic            byte_offset_bit,
	output logic            sys_clock_out
);
	ebc_state_t state;
	ebc_state_t next_state;
	logic [1:0]  ack_s1;
	logic [1:0]  ack_s2;
	logic        bus_error_n_s1;
	logic        bus_error_n_s2;
	logic        halt_s1;
	logic        halt_s2;
	logic [1:0]  ack_seen;
	logic        bus_error_n_seen;
	logic        halt_seen;
	logic        timeout;
	logic [3:0]  ft_count;
	logic [1:0]  remain;
	logic [23:0] cur_addr;
	logic [31:0] shreg;
	logic        active;
	logic        term;
	logic [1:0]  moved;
	logic        busy;

	// Bytes moved per cycle for a port width, size and odd address.
	function automatic logic [1:0] bytes_moved(input logic [1:0] ack,
			input logic [1:0] left, input logic odd);
		if (ack == ACK_PORT8 || left == SIZE_BYTE || odd) begin
			return 2'h1;
		end
		return 2'h2;
	endfunction

	// Two-stage input synchronizers; only the second stage is used.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ack_s1  <= ACK_WAIT;
			ack_s2  <= ACK_WAIT;
			bus_error_n_s1 <= 1'b1;
			bus_error_n_s2 <= 1'b1;
			halt_s1 <= 1'b1;
			halt_s2 <= 1'b1;
		end else begin
			ack_s1  <= size_ack_n;
			ack_s2  <= ack_s1;
			bus_error_n_s1 <= bus_error_n;
			bus_error_n_s2 <= bus_error_n_s1;
			halt_s1 <= halt_n;
			halt_s2 <= halt_s1;
		end
	end

	always_comb begin
		active    = state inside {EBC_STRB, EBC_WAIT};
		bus_error_n_seen = !bus_error_n_s2 || timeout;
		// Halt beside a bus error or a monitor timeout is bus error alone.
		halt_seen = !halt_s2 && !bus_error_n_seen;
		if (busy && bus.data_strobe_n == 1'b0 && req.fast
				&& ft_count == 4'h0) begin
			ack_seen = ACK_PORT16;
		end else if (req.fast) begin
			ack_seen = ACK_WAIT;
		end else begin
			ack_seen = ack_s2;
		end
		// Reserved code 00 is treated as no acknowledge.
		term  = active && (ack_seen == ACK_PORT8 || ack_seen == ACK_PORT16
			|| bus_error_n_seen || halt_seen);
		moved = bytes_moved(ack_seen, remain, cur_addr[0]);
	end

	ebc_bus_monitor u_bmon (
		.clk                (clk),
		.nrst               (nrst),
		.active             (active && !req.fast),
		.clear              (term),
		.bus_monitor_period (bus_monitor_period),
		.timeout            (timeout)
	);

	always_comb begin
		next_state = state;
		unique case (state)
			EBC_IDLE: begin
				if (req_valid && req.internal) begin
					next_state = EBC_INT;
				end else if (req_valid) begin
					next_state = EBC_ADDR;
				end
			end
			EBC_INT:   next_state = EBC_IDLE;
			EBC_ADDR:  next_state = req.fast ? EBC_LATCH : EBC_STRB;
			EBC_STRB: begin
				next_state = term ? EBC_LATCH : EBC_WAIT;
			end
			EBC_WAIT: begin
				next_state = term ? EBC_LATCH : EBC_WAIT;
			end
			EBC_LATCH: begin
				next_state = (req.fast && ft_count != 4'h0) ? EBC_LATCH
					: EBC_END;
			end
			EBC_END: begin
				next_state = EBC_IDLE;
			end
			default:   next_state = EBC_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= EBC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ft_count <= FT_WAIT_RESET;
		end else if (state == EBC_ADDR) begin
			ft_count <= ft_wait_states;
		end else if (ft_count != 4'h0) begin
			ft_count <= ft_count - 4'h1;
		end
	end

	// Cycle record: address, bytes left, result shift register.
	logic        bus_error_n_hold;
	logic        halt_hold;
	logic [1:0]  last_moved;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			busy       <= 1'b0;
			remain     <= SIZE_LONG;
			cur_addr   <= 24'h00_0000;
			shreg      <= 32'h0000_0000;
			bus_error_n_hold  <= 1'b0;
			halt_hold  <= 1'b0;
			last_moved <= 2'h0;
		end else if (state == EBC_IDLE && req_valid && !busy) begin
			busy      <= 1'b1;
			remain    <= req.size;
			cur_addr  <= req.addr;
			shreg     <= req.wdata;
			bus_error_n_hold <= 1'b0;
			halt_hold <= 1'b0;
		end else if (term) begin
			bus_error_n_hold  <= bus_error_n_seen;
			halt_hold  <= halt_seen;
			last_moved <= moved;
		end else if (state == EBC_LATCH && next_state == EBC_END) begin
			// Data is taken one clock after the acknowledge was seen.
			if (req.fast) begin
				last_moved <= bytes_moved(ACK_PORT16, remain, cur_addr[0]);
			end
			if (!bus.read_not_write) begin
				shreg <= shreg;
			end else if ((req.fast ? bytes_moved(ACK_PORT16, remain,
					cur_addr[0]) : last_moved) == 2'h2) begin
				shreg <= {shreg[15:0], data_in};
			end else if (cur_addr[0] && !(ack_s2 == ACK_PORT8)) begin
				shreg <= {shreg[23:0], data_in[7:0]};
			end else begin
				shreg <= {shreg[23:0], data_in[15:8]};
			end
		end else if (state == EBC_END) begin
			if (!bus.read_not_write) begin
				shreg <= last_moved == 2'h2 ? {shreg[15:0], 16'h0000}
					: {shreg[23:0], 8'h00};
			end
			remain   <= remain - last_moved;
			cur_addr <= cur_addr + 24'(last_moved);
			if (bus_error_n_hold || halt_hold || remain == last_moved) begin
				busy <= 1'b0;
			end
		end else if (state == EBC_INT) begin
			busy <= 1'b0;
		end
	end

	// Outputs at the start and end of each cycle come from flip-flops.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			bus.addr_strobe_n  <= 1'b1;
			bus.data_strobe_n  <= 1'b1;
			bus.read_not_write <= 1'b1;
			bus.xfer_size      <= SIZE_BYTE;
			bus.addr           <= 24'h00_0000;
			byte_offset_bit    <= 1'b0;
			data_out           <= 16'h0000;
			data_oe_n          <= 1'b1;
		end else begin
			if (next_state == EBC_ADDR && !busy) begin
				// A new request is not in the cycle record yet.
				bus.addr        <= req.addr;
				byte_offset_bit <= req.addr[0];
				bus.xfer_size   <= req.size;
				bus.read_not_write <= !req.write;
			end else if (state == EBC_ADDR || next_state == EBC_ADDR) begin
				bus.addr        <= cur_addr;
				byte_offset_bit <= cur_addr[0];
				bus.xfer_size   <= remain;
				bus.read_not_write <= !req.write;
			end
			bus.addr_strobe_n <= !(next_state inside {EBC_STRB, EBC_WAIT,
				EBC_LATCH} && !(next_state == EBC_LATCH && state == EBC_LATCH
				&& !req.fast));
			bus.data_strobe_n <= !(next_state inside {EBC_STRB, EBC_WAIT}
				|| (next_state == EBC_LATCH && req.fast && !req.write));
			data_oe_n <= !(req.write && next_state inside {EBC_STRB,
				EBC_WAIT, EBC_LATCH});
			// A last or odd-addressed byte is mirrored on both lanes for any port width.
			data_out <= (remain == SIZE_BYTE || cur_addr[0])
				? {2{shreg[31:24]}} : shreg[31:16];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rsp <= '0;
		end else begin
			rsp.done      <= (state == EBC_INT) || (state == EBC_END
				&& (bus_error_n_hold || halt_hold || remain == last_moved));
			rsp.bus_error <= state == EBC_END && bus_error_n_hold;
			rsp.halted    <= state == EBC_END && halt_hold;
			rsp.rdata     <= state == EBC_END ? shreg : rsp.rdata;
		end
	end

	// The clock output is low in reset and held high in every state after it.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sys_clock_out <= 1'b0;
		end else begin
			sys_clock_out <= 1'b1;
		end
	end

	assign req_ready = state == EBC_IDLE && !busy;

	sequence s_int_start;
		state == EBC_IDLE && req_valid && req.internal && !busy;
	endsequence

	AST_INT_TWO: assert property (@(posedge clk) disable iff (!nrst)
		s_int_start |=> ##1 rsp.done)
		else $error("Internal access did not end in two clocks.");

	AST_STRB_AFTER_ADDR: assert property (@(posedge clk) disable iff (!nrst)
		$fell(bus.addr_strobe_n) |-> $past(state) == EBC_ADDR)
		else $error("Address strobe came without address phase.");

	AST_WAIT_NO_ACK: assert property (@(posedge clk) disable iff (!nrst)
		state == EBC_WAIT && !term |=> state == EBC_WAIT)
		else $error("Wait state left without termination.");

	AST_THREE_MIN: assert property (@(posedge clk) disable iff (!nrst)
		state == EBC_ADDR && !req.fast |=> !(state inside {EBC_END})
		##1 !(state inside {EBC_END}))
		else $error("Regular cycle shorter than three clocks.");

	AST_FAST_TWO: assert property (@(posedge clk) disable iff (!nrst)
		state == EBC_ADDR && req.fast && ft_wait_states == 4'h0
		|=> ##1 state == EBC_END)
		else $error("Fast cycle did not end in two clocks.");

	AST_BUS_ERROR_N_WINS: assert property (@(posedge clk) disable iff (!nrst)
		term && bus_error_n_seen |=> bus_error_n_hold && !halt_hold)
		else $error("Halt with bus error was not treated as bus error.");

	AST_LATCH_NEXT: assert property (@(posedge clk) disable iff (!nrst)
		term && !req.fast |=> state == EBC_LATCH)
		else $error("Data not taken the clock after acknowledge.");

	AST_SIZE_OUT: assert property (@(posedge clk) disable iff (!nrst)
		state == EBC_STRB |-> bus.xfer_size == remain)
		else $error("Size outputs do not show bytes left.");

	// The reserved code must never end a cycle on its own.
	AST_RSVD_WAITS: assert property (@(posedge clk) disable iff (!nrst)
		state == EBC_WAIT && !req.fast && ack_s2 == ACK_RSVD && bus_error_n_s2
		&& halt_s2 && !timeout |=> state == EBC_WAIT)
		else $error("Reserved acknowledge code ended a cycle.");

	AST_ACK_SYNC: assert property (@(posedge clk) disable iff (!nrst)
		ack_s2 == $past(size_ack_n, 2))
		else $error("Acknowledge did not pass two synchronizer stages.");
endmodule

// >>> test/ebc_periph_model.sv
// Peripheral model on the external bus: size acknowledge, data, errors.
// Assumes the controller changes its bus outputs on rising clk edges.
`timescale 1ns/1ps
module ebc_periph_model
	import ebc_pkg::*;
(
	input  wire logic              clk,
	input  wire ebc_pkg::ebc_bus_t bus,
	input  wire logic [15:0]       data_out,
	input  wire logic              port16,
	input  wire logic [3:0]        delay,
	input  wire logic [1:0]        mode,
	output logic [1:0]             size_ack_n,
	output logic                   bus_error_n,
	output logic                   halt_n,
	output logic [15:0]            data_in
);
	logic [7:0]  mem [256];
	logic [23:0] a;
	logic [15:0] idle_data;
	int          cnt;

	assign a = bus.addr;

	// Read data follows the address at once, so that a fast cycle with no
	// wait states finds it in place when the controller samples.
	assign data_in = (!bus.addr_strobe_n && bus.read_not_write)
		? (port16 ? {a[7:1], 1'b0, a[7:1], 1'b1} ^ 16'h3c3c
		: {a[7:0] ^ 8'h3c, ~idle_data[7:0]}) : idle_data;

	initial begin
		size_ack_n = 2'h3;
		bus_error_n = 1'b1;
		halt_n = 1'b1;
		idle_data = 16'h0000;
		cnt = 0;
	end

	// Mode 0 answers, 1 bus error, 2 bus error with halt, 3 stays silent.
	always @(posedge clk) begin
		if (bus.addr_strobe_n) begin
			cnt <= 0;
			size_ack_n <= 2'h3;
			bus_error_n <= 1'b1;
			halt_n <= 1'b1;
			// A released bus toggles so that stale data never looks valid.
			idle_data <= ~idle_data;
		end else begin
			cnt <= cnt + 1;
			if (cnt == int'(delay)) begin
				if (mode == 2'h0)
					size_ack_n <= port16 ? 2'h1 : 2'h2;
				if (mode == 2'h1 || mode == 2'h2)
					bus_error_n <= 1'b0;
				if (mode == 2'h2)
					halt_n <= 1'b0;
				if (bus.read_not_write)
					cnt <= cnt + 1;
				else if (!port16)
					mem[a[7:0]] <= data_out[15:8];
				else begin
					if (!a[0])
						mem[a[7:0]] <= data_out[15:8];
					if (a[0] || bus.xfer_size != SIZE_BYTE)
						mem[a[7:0] | 8'h01] <= data_out[7:0];
				end
			end
		end
	end
endmodule

// >>> test/tb.sv
// Self-checking bench of the bus cycle controller and a peripheral model.
// Assumes one 10 MHz clock and the request handshake of the controller.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
	$display("MISMATCH t=%0t got %0h want %0h", $time, a, b); end end
module tb import ebc_pkg::*;;
	typedef struct packed {
		logic        rd;
		logic        err;
		logic [31:0] mask;
		logic [31:0] data;
	} ebc_exp_t;

	logic        clk, nrst, req_valid, req_ready, data_oe_n, port16, seen;
	logic        byte_offset_bit, sys_clock_out, bus_error_n, halt_n;
	logic [1:0]  size_ack_n, bus_monitor_period, mode, sz_seen;
	logic [3:0]  ft_wait_states, delay, d;
	logic [15:0] data_in, data_out, w;
	logic [23:0] a_seen;
	ebc_req_t    req;
	ebc_rsp_t    rsp;
	ebc_bus_t    bus;
	ebc_exp_t    q[$];
	ebc_exp_t    e;
	int          failures, n_checks, lat0, lat, lt;
	integer      seed;

	ebc_cycle_ctrl dut (.clk(clk), .nrst(nrst), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .rsp(rsp),
		.ft_wait_states(ft_wait_states),
		.bus_monitor_period(bus_monitor_period), .size_ack_n(size_ack_n),
		.bus_error_n(bus_error_n), .halt_n(halt_n), .data_in(data_in),
		.data_out(data_out), .data_oe_n(data_oe_n), .bus(bus),
		.byte_offset_bit(byte_offset_bit), .sys_clock_out(sys_clock_out));

	ebc_periph_model pm (.clk(clk), .bus(bus), .data_out(data_out),
		.port16(port16), .delay(delay), .mode(mode),
		.size_ack_n(size_ack_n), .bus_error_n(bus_error_n),
		.halt_n(halt_n), .data_in(data_in));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(negedge clk) begin
		if (!bus.addr_strobe_n && !seen) begin
			seen = 1'b1;
			sz_seen = bus.xfer_size;
			a_seen = bus.addr;
		end
		if (rsp.done || rsp.bus_error || rsp.halted) begin
			e = q.pop_front();
			`CHK(rsp.bus_error, e.err)
			`CHK(rsp.halted, 1'b0)
			if (e.rd) `CHK(rsp.rdata & e.mask, e.data)
		end
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic run(input logic i, f, wr, input logic [1:0] sz,
			input logic [23:0] a, input logic p, input logic [3:0] dl,
			input logic [1:0] m, input logic [31:0] wd, output int l);
		int       n;
		ebc_exp_t x;
		n = (sz == 2'h0) ? 4 : int'(sz);
		x = '0;
		x.err = !i && !f && m != 2'h0;
		x.rd = !wr && !i && !x.err;
		for (int k = 0; k < n; k++) begin
			x.mask = {x.mask[23:0], 8'hff};
			x.data = {x.data[23:0], 8'(a + 24'(k)) ^ 8'h3c};
		end
		q.push_back(x);
		seen = 1'b0;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{i, f, wr, sz, a, wd};
		port16 <= p;
		delay <= dl;
		mode <= m;
		l = 0;
		do begin
			@(posedge clk);
			#1;
			l++;
		end while (!(rsp.done || rsp.bus_error || rsp.halted) && l < 300);
		req_valid <= 1'b0;
		`CHK(l < 300, 1'b1)
		if (!i && !f) begin
			`CHK(sz_seen, sz)
			`CHK(a_seen, a)
		end
		if (wr && !x.err && !i)
			for (int k = 0; k < n; k++)
				`CHK(pm.mem[8'(a + 24'(k))], wd[31 - 8 * k -: 8])
		$display("test i%0b f%0b w%0b size %0d lat %0d", i, f, wr, sz, l);
	endtask

	initial begin
		nrst = 1'b0;
		req_valid = 1'b0;
		req = '0;
		port16 = 1'b1;
		delay = 4'h0;
		mode = 2'h0;
		ft_wait_states = 4'h0;
		bus_monitor_period = 2'h0;
		failures = 0;
		n_checks = 0;
		seed = 32'hb230_d4ad;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		run(1, 0, 0, SIZE_WORD, 24'h10, 1, 0, 0, 0, lat);
		`CHK(lat <= 3, 1'b1)
		run(0, 0, 0, SIZE_WORD, 24'h20, 1, 0, 0, 0, lat0);
		`CHK(lat0 >= 4, 1'b1)
		d = 4'($random(seed) & 7) + 4'h1;
		run(0, 0, 0, SIZE_WORD, 24'h20, 1, d, 0, 0, lat);
		`CHK(lat, lat0 + int'(d))
		run(0, 0, 0, SIZE_LONG, 24'h40, 1, 1, 0, 0, lat);
		run(0, 0, 0, SIZE_LONG, 24'h44, 0, 0, 0, 0, lat);
		run(0, 0, 0, SIZE_BYTE, 24'h51, 0, 2, 0, 0, lat);
		run(0, 0, 0, SIZE_BYTE, 24'h53, 1, 0, 0, 0, lat);
		w = 16'($random(seed));
		run(0, 0, 1, SIZE_WORD, 24'h60, 1, 0, 0, {w, w}, lat);
		run(0, 0, 1, SIZE_WORD, 24'h66, 0, 1, 0, {w, w}, lat);
		run(0, 0, 1, SIZE_BYTE, 24'h69, 0, 0, 0, {4{w[7:0]}}, lat);
		run(0, 0, 0, SIZE_WORD, 24'h70, 1, 1, 1, 0, lat);
		run(0, 0, 0, SIZE_WORD, 24'h72, 1, 1, 2, 0, lat);
		run(0, 0, 0, SIZE_WORD, 24'h74, 1, 0, 3, 0, lt);
		bus_monitor_period = 2'h1;
		run(0, 0, 0, SIZE_WORD, 24'h76, 1, 0, 3, 0, lat);
		`CHK(lat - lt, 8)
		run(0, 1, 0, SIZE_WORD, 24'h78, 1, 0, 3, 0, lt);
		`CHK(lt < lat0, 1'b1)
		ft_wait_states = d;
		run(0, 1, 0, SIZE_WORD, 24'h78, 1, 0, 3, 0, lat);
		`CHK(lat, lt + int'(d))
		repeat (3) @(posedge clk);
		`CHK(q.size(), 0)
		tally_and_finish();
	end

	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule
